// [design/pic_irq_ctrl.sv]
// Interrupt enable, status, clear and set logic of the power and clock control unit.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
module pic_irq_ctrl (
   input  wire logic        i_clk,       // Unit clock, 25 MHz.
   input  wire logic        i_resetn,    // Asynchronous reset, active low.
   input  wire logic [31:0] i_src,       // Source levels from pads and monitors.
   input  wire logic [13:0] i_addr,      // Register byte address.
   input  wire logic [31:0] i_wdata,     // Register write data.
   input  wire logic        i_wr,        // Write strobe, one cycle.
   input  wire logic        i_rd,        // Read strobe, one cycle.
   output logic      [31:0] o_rdata,     // Read data, valid the cycle after i_rd.
   output logic             o_irq        // Level interrupt, high while enabled flag set.
);
   logic        rst_meta;
   logic        rst_n;
   logic [31:0] src_meta;
   logic [31:0] src_sync;
   logic [31:0] src_prev;
   logic [31:0] enable;
   logic [31:0] status;
   logic [31:0] rdata;
   logic [31:0] next_enable;
   logic [31:0] next_status;
   logic [31:0] next_rdata;
   logic [31:0] src_rise;
   logic [31:0] wdata_m;
   logic        wr_en_set;
   logic        wr_en_clear;
   logic        hit_status;
   logic        hit_en_read;
   logic [31:0] clr_hold;
   logic [31:0] set_hold;
   logic [31:0] en_word;
   logic [31:0] status_word;
   logic [31:0] clr_word;
   logic [31:0] set_word;
   // Per-source field views; bit 11 of every pad field belongs to pad 12.
   logic [11:0] pad_rise_irq_en;
   logic        aux_bus_supply_high_irq_en;
   logic        rf_field_activity_irq_en;
   logic        bus_supply_low_irq_en;
   logic        aux_bus_supply_low_irq_en;
   logic        power_stage_current_limit_irq_en;
   logic        temp_sensor1_err_irq_en;
   logic        temp_sensor0_err_irq_en;
   logic        suspend_prevented_irq_en;
   logic        suspend_exit_irq_en;
   logic        pin_irq_en;
   logic [11:0] pad_rise_irq_flag;
   logic        aux_bus_supply_high_irq_flag;
   logic        rf_field_activity_irq_flag;
   logic        bus_supply_low_irq_flag;
   logic        aux_bus_supply_low_irq_flag;
   logic        power_stage_current_limit_irq_flag;
   logic        temp_sensor1_err_irq_flag;
   logic        temp_sensor0_err_irq_flag;
   logic        suspend_prevented_irq_flag;
   logic        suspend_exit_irq_flag;
   logic        pin_irq_flag;
   logic [11:0] pad_rise_irq_clr;
   logic        aux_bus_supply_high_irq_clr;
   logic        rf_field_activity_irq_clr;
   logic        bus_supply_low_irq_clr;
   logic        aux_bus_supply_low_irq_clr;
   logic        power_stage_current_limit_irq_clr;
   logic        temp_sensor1_err_irq_clr;
   logic        temp_sensor0_err_irq_clr;
   logic        suspend_prevented_irq_clr;
   logic        suspend_exit_irq_clr;
   logic        pin_irq_clr;
   logic [11:0] pad_rise_irq_set;
   logic        aux_bus_supply_high_irq_set;
   logic        rf_field_activity_irq_set;
   logic        bus_supply_low_irq_set;
   logic        aux_bus_supply_low_irq_set;
   logic        power_stage_current_limit_irq_set;
   logic        temp_sensor1_err_irq_set;
   logic        temp_sensor0_err_irq_set;
   logic        suspend_prevented_irq_set;
   logic        suspend_exit_irq_set;
   logic        pin_irq_set;

   pic_pulse_if clr_if ();
   pic_pulse_if set_if ();

   // Reset is released through two flops so every flop leaves reset on the same edge.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Sources come from pads and analog monitors, so they are synchronised first.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         src_meta <= 32'h0000_0000;
         src_sync <= 32'h0000_0000;
         src_prev <= 32'h0000_0000;
      end else begin
         src_meta <= i_src;
         src_sync <= src_meta;
         src_prev <= src_sync;
      end
   end

   // Every register hit goes through one comparator shape, so a change of address width
   // touches a single place.
   function automatic logic addr_is(input logic [13:0] addr, input logic [13:0] off);
      return addr == off;
   endfunction

   // Every source raises its flag on a rising level; a held level fires only once.
   assign src_rise    = src_sync & ~src_prev & pic_pkg::SRC_MASK;
   assign wdata_m     = i_wdata & pic_pkg::SRC_MASK;
   assign wr_en_set   = i_wr && addr_is(i_addr, pic_pkg::OFF_EN_SET);
   assign wr_en_clear = i_wr && addr_is(i_addr, pic_pkg::OFF_EN_CLEAR);
   assign hit_status  = addr_is(i_addr, pic_pkg::OFF_STATUS);
   assign hit_en_read = addr_is(i_addr, pic_pkg::OFF_EN_READ);

   assign clr_if.wr    = i_wr && addr_is(i_addr, pic_pkg::OFF_CLR_PULSE);
   assign clr_if.wdata = i_wdata;
   assign set_if.wr    = i_wr && addr_is(i_addr, pic_pkg::OFF_SET_PULSE);
   assign set_if.wdata = i_wdata;
   // The held pulse bits are read through plain copies so the field views stay local.
   assign clr_hold     = clr_if.hold;
   assign set_hold     = set_if.hold;

   pic_pulse_reg #(
      .HOLD (pic_pkg::PULSE_HOLD)
   ) u_clr_pulse (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .bus     (clr_if.pulse)
   );

   pic_pulse_reg #(
      .HOLD (pic_pkg::PULSE_HOLD)
   ) u_set_pulse (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .bus     (set_if.pulse)
   );

   // Writing one enables, writing one to the disable register withdraws, zero is no-op.
   assign next_enable = wr_en_set   ? (enable | wdata_m)  :
                        wr_en_clear ? (enable & ~wdata_m) :
                                      enable;

   // Rebuilds a register word from its per-source fields. Reserved positions come out
   // as zero, which keeps them reading zero whatever software wrote there.
   function automatic logic [31:0] pack_src(
      input logic [11:0] pads,        // Pads 12 down to 1, bit 11 is pad 12.
      input logic        aux_high,    // Aux bus supply above threshold.
      input logic        rf_field,    // Contactless field activity.
      input logic        bus_low,     // Bus supply fell low.
      input logic        aux_low,     // Aux bus supply fell low.
      input logic        cur_lim,     // Power stage current limiter active.
      input logic        temp1,       // Temperature sensor 1 error.
      input logic        temp0,       // Temperature sensor 0 error.
      input logic        susp_prev,   // Requested suspend was prevented.
      input logic        susp_exit,   // Exit from suspend.
      input logic        pin          // General pin interrupt.
   );
      logic [31:0] word;
      word                                    = 32'h0000_0000;
      word[pic_pkg::PAD_MSB:pic_pkg::PAD_LSB] = pads;
      word[pic_pkg::AUX_HIGH_BIT]             = aux_high;
      word[pic_pkg::RF_FIELD_BIT]             = rf_field;
      word[pic_pkg::BUS_LOW_BIT]              = bus_low;
      word[pic_pkg::AUX_LOW_BIT]              = aux_low;
      word[pic_pkg::CUR_LIM_BIT]              = cur_lim;
      word[pic_pkg::TEMP1_BIT]                = temp1;
      word[pic_pkg::TEMP0_BIT]                = temp0;
      word[pic_pkg::SUSP_PREV_BIT]            = susp_prev;
      word[pic_pkg::SUSP_EXIT_BIT]            = susp_exit;
      word[pic_pkg::PIN_IRQ_BIT]              = pin;
      return word;
   endfunction

   // Named field views of each source vector. Every word is rebuilt through pack_src,
   // so one table of positions serves readback, status and both pulse registers.
   assign pad_rise_irq_en = enable[pic_pkg::PAD_MSB:pic_pkg::PAD_LSB];
   assign aux_bus_supply_high_irq_en = enable[pic_pkg::AUX_HIGH_BIT];
   assign rf_field_activity_irq_en = enable[pic_pkg::RF_FIELD_BIT];
   assign bus_supply_low_irq_en = enable[pic_pkg::BUS_LOW_BIT];
   assign aux_bus_supply_low_irq_en = enable[pic_pkg::AUX_LOW_BIT];
   assign power_stage_current_limit_irq_en = enable[pic_pkg::CUR_LIM_BIT];
   assign temp_sensor1_err_irq_en = enable[pic_pkg::TEMP1_BIT];
   assign temp_sensor0_err_irq_en = enable[pic_pkg::TEMP0_BIT];
   assign suspend_prevented_irq_en = enable[pic_pkg::SUSP_PREV_BIT];
   assign suspend_exit_irq_en = enable[pic_pkg::SUSP_EXIT_BIT];
   assign pin_irq_en = enable[pic_pkg::PIN_IRQ_BIT];
   assign en_word = pack_src(pad_rise_irq_en, aux_bus_supply_high_irq_en,
      rf_field_activity_irq_en, bus_supply_low_irq_en, aux_bus_supply_low_irq_en,
      power_stage_current_limit_irq_en, temp_sensor1_err_irq_en, temp_sensor0_err_irq_en,
      suspend_prevented_irq_en, suspend_exit_irq_en, pin_irq_en);

   // Pending flags sit at the same positions as their enables, so software can mask
   // the status word with the readback word directly.
   assign pad_rise_irq_flag = status[pic_pkg::PAD_MSB:pic_pkg::PAD_LSB];
   assign aux_bus_supply_high_irq_flag = status[pic_pkg::AUX_HIGH_BIT];
   assign rf_field_activity_irq_flag = status[pic_pkg::RF_FIELD_BIT];
   assign bus_supply_low_irq_flag = status[pic_pkg::BUS_LOW_BIT];
   assign aux_bus_supply_low_irq_flag = status[pic_pkg::AUX_LOW_BIT];
   assign power_stage_current_limit_irq_flag = status[pic_pkg::CUR_LIM_BIT];
   assign temp_sensor1_err_irq_flag = status[pic_pkg::TEMP1_BIT];
   assign temp_sensor0_err_irq_flag = status[pic_pkg::TEMP0_BIT];
   assign suspend_prevented_irq_flag = status[pic_pkg::SUSP_PREV_BIT];
   assign suspend_exit_irq_flag = status[pic_pkg::SUSP_EXIT_BIT];
   assign pin_irq_flag = status[pic_pkg::PIN_IRQ_BIT];
   assign status_word = pack_src(pad_rise_irq_flag, aux_bus_supply_high_irq_flag,
      rf_field_activity_irq_flag, bus_supply_low_irq_flag, aux_bus_supply_low_irq_flag,
      power_stage_current_limit_irq_flag, temp_sensor1_err_irq_flag, temp_sensor0_err_irq_flag,
      suspend_prevented_irq_flag, suspend_exit_irq_flag, pin_irq_flag);

   // Clear pulses are held for the full hold time, so each field stays high two cycles.
   assign pad_rise_irq_clr = clr_hold[pic_pkg::PAD_MSB:pic_pkg::PAD_LSB];
   assign aux_bus_supply_high_irq_clr = clr_hold[pic_pkg::AUX_HIGH_BIT];
   assign rf_field_activity_irq_clr = clr_hold[pic_pkg::RF_FIELD_BIT];
   assign bus_supply_low_irq_clr = clr_hold[pic_pkg::BUS_LOW_BIT];
   assign aux_bus_supply_low_irq_clr = clr_hold[pic_pkg::AUX_LOW_BIT];
   assign power_stage_current_limit_irq_clr = clr_hold[pic_pkg::CUR_LIM_BIT];
   assign temp_sensor1_err_irq_clr = clr_hold[pic_pkg::TEMP1_BIT];
   assign temp_sensor0_err_irq_clr = clr_hold[pic_pkg::TEMP0_BIT];
   assign suspend_prevented_irq_clr = clr_hold[pic_pkg::SUSP_PREV_BIT];
   assign suspend_exit_irq_clr = clr_hold[pic_pkg::SUSP_EXIT_BIT];
   assign pin_irq_clr = clr_hold[pic_pkg::PIN_IRQ_BIT];
   assign clr_word = pack_src(pad_rise_irq_clr, aux_bus_supply_high_irq_clr,
      rf_field_activity_irq_clr, bus_supply_low_irq_clr, aux_bus_supply_low_irq_clr,
      power_stage_current_limit_irq_clr, temp_sensor1_err_irq_clr, temp_sensor0_err_irq_clr,
      suspend_prevented_irq_clr, suspend_exit_irq_clr, pin_irq_clr);

   // Software set pulses let a handler be tested without driving the real source.
   assign pad_rise_irq_set = set_hold[pic_pkg::PAD_MSB:pic_pkg::PAD_LSB];
   assign aux_bus_supply_high_irq_set = set_hold[pic_pkg::AUX_HIGH_BIT];
   assign rf_field_activity_irq_set = set_hold[pic_pkg::RF_FIELD_BIT];
   assign bus_supply_low_irq_set = set_hold[pic_pkg::BUS_LOW_BIT];
   assign aux_bus_supply_low_irq_set = set_hold[pic_pkg::AUX_LOW_BIT];
   assign power_stage_current_limit_irq_set = set_hold[pic_pkg::CUR_LIM_BIT];
   assign temp_sensor1_err_irq_set = set_hold[pic_pkg::TEMP1_BIT];
   assign temp_sensor0_err_irq_set = set_hold[pic_pkg::TEMP0_BIT];
   assign suspend_prevented_irq_set = set_hold[pic_pkg::SUSP_PREV_BIT];
   assign suspend_exit_irq_set = set_hold[pic_pkg::SUSP_EXIT_BIT];
   assign pin_irq_set = set_hold[pic_pkg::PIN_IRQ_BIT];
   assign set_word = pack_src(pad_rise_irq_set, aux_bus_supply_high_irq_set,
      rf_field_activity_irq_set, bus_supply_low_irq_set, aux_bus_supply_low_irq_set,
      power_stage_current_limit_irq_set, temp_sensor1_err_irq_set, temp_sensor0_err_irq_set,
      suspend_prevented_irq_set, suspend_exit_irq_set, pin_irq_set);

   // Zero bits of the clear pulse keep the flag; an event in the first of the two clear cycles is cleared again by the second.
   assign next_status = ((status & ~clr_word) | src_rise | set_word)
                        & pic_pkg::SRC_MASK;

   // Readback is rebuilt from the field views, so reserved positions always read zero.
   assign next_rdata  = hit_en_read ? en_word     :
                        hit_status  ? status_word :
                                      32'h0000_0000;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         enable <= pic_pkg::RESET_VALUE;
         status <= pic_pkg::RESET_VALUE;
      end else begin
         enable <= next_enable;
         status <= next_status;
      end
   end

   // Read data stand only in the cycle after the strobe and are zero otherwise.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= i_rd ? next_rdata : 32'h0000_0000;
      end
   end

   assign o_rdata = rdata;
   assign o_irq   = |(status & enable);
endmodule // pic_irq_ctrl

// [common/pic_pkg.sv]
// Package with the register map, field layout and timing counts of the interrupt block.
package pic_pkg;
   localparam int unsigned ADDR_W        = 14;
   localparam int unsigned DATA_W        = 32;
   // Register byte offsets.
   localparam logic [13:0] OFF_EN_CLEAR  = 14'h3fd4;
   localparam logic [13:0] OFF_EN_SET    = 14'h3fd8;
   localparam logic [13:0] OFF_STATUS    = 14'h3fe0;
   localparam logic [13:0] OFF_EN_READ   = 14'h3fe4;
   localparam logic [13:0] OFF_CLR_PULSE = 14'h3fe8;
   localparam logic [13:0] OFF_SET_PULSE = 14'h3fec;
   // Field positions of the source vector.
   localparam int unsigned PAD_LSB       = 16;
   localparam int unsigned PAD_MSB       = 27;
   localparam int unsigned AUX_HIGH_BIT  = 10;
   localparam int unsigned RF_FIELD_BIT  = 9;
   localparam int unsigned BUS_LOW_BIT   = 8;
   localparam int unsigned AUX_LOW_BIT   = 7;
   localparam int unsigned CUR_LIM_BIT   = 6;
   localparam int unsigned TEMP1_BIT     = 5;
   localparam int unsigned TEMP0_BIT     = 4;
   localparam int unsigned SUSP_PREV_BIT = 3;
   localparam int unsigned SUSP_EXIT_BIT = 1;
   localparam int unsigned PIN_IRQ_BIT   = 0;
   // Implemented bits; 31:28, 15:11 and 2 are reserved.
   localparam logic [31:0] SRC_MASK      = 32'h0fff_07fb;
   localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;
   // Cycles a written clear or set bit stays high before it drops by itself.
   localparam int unsigned PULSE_HOLD    = 2;
endpackage

// [common/pic_pulse_if.sv]
// Interface carrying a self-clearing pulse register write and its held bits.
`timescale 1ns/1ns
interface pic_pulse_if;
   logic        wr;
   logic [31:0] wdata;
   logic [31:0] hold;
   modport ctrl (output wr, output wdata, input hold);
   modport pulse (input wr, input wdata, output hold);
endinterface

// [design/pic_pulse_reg.sv]
// Write-only register whose bits written with one drop back to zero by themselves.
`timescale 1ns/1ns
module pic_pulse_reg #(
   parameter int unsigned HOLD = pic_pkg::PULSE_HOLD
) (
   input  wire logic   i_clk,     // Unit clock.
   input  wire logic   i_rst_n,   // Synchronised reset, active low.
   pic_pulse_if.pulse  bus        // Write strobe, data and held bits.
);
   localparam int unsigned CW = $clog2(HOLD + 1);
   localparam logic [CW-1:0] LAST = CW'(HOLD - 1);

   logic [31:0]   hold;
   logic [CW-1:0] age;

   assign bus.hold = hold;

   // A new write restarts the hold and replaces the held bits, so only the last of back-to-back writes gets full length.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold <= 32'h0000_0000;
         age  <= '0;
      end else if (bus.wr) begin
         hold <= bus.wdata & pic_pkg::SRC_MASK;
         age  <= '0;
      end else if (age == LAST) begin
         hold <= 32'h0000_0000;
      end else begin
         age  <= age + CW'(1);
      end
   end
endmodule // pic_pulse_reg

// [bench/pic_irq_ctrl_chk.sv]
// Port checker for the interrupt block.
`timescale 1ns/1ns
module pic_irq_ctrl_chk (
   input wire logic        i_clk,    // Clock.
   input wire logic        i_resetn, // Reset.
   input wire logic [31:0] i_src,    // Sources.
   input wire logic [13:0] i_addr,   // Address.
   input wire logic [31:0] i_wdata,  // Data in.
   input wire logic        i_wr,     // Write.
   input wire logic        i_rd,     // Read.
   input wire logic [31:0] o_rdata,  // Data out.
   input wire logic        o_irq     // Interrupt.
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   property p_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("data outside answer");
   property p_rsv; (o_rdata & ~pic_pkg::SRC_MASK) == 32'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   property p_wo; $past(i_rd) && $past(i_addr) == pic_pkg::OFF_CLR_PULSE |-> o_rdata == 32'h0;
   endproperty
   a_wo: assert property (p_wo) else $error("clear register readable");
   property p_set; (i_wr && i_addr == pic_pkg::OFF_EN_SET) ##1
      (i_rd && i_addr == pic_pkg::OFF_EN_READ) |=>
      (o_rdata & $past(i_wdata, 2) & pic_pkg::SRC_MASK) == ($past(i_wdata, 2) & pic_pkg::SRC_MASK);
   endproperty
   a_set: assert property (p_set) else $error("enable not set");
   property p_enclr; (i_wr && i_addr == pic_pkg::OFF_EN_CLEAR && i_wdata == 32'hffff_ffff) ##1
      (i_rd && i_addr == pic_pkg::OFF_EN_READ) |=> o_rdata == 32'h0; endproperty
   a_enclr: assert property (p_enclr) else $error("enable not cleared");
   property p_ro; (i_rd && i_addr == pic_pkg::OFF_EN_READ) ##1
      (i_wr && i_addr == pic_pkg::OFF_EN_READ) ##1 (i_rd && i_addr == pic_pkg::OFF_EN_READ)
      |=> o_rdata == $past(o_rdata, 2); endproperty
   a_ro: assert property (p_ro) else $error("readback was writable");
   property p_fall; $fell(o_irq) |-> $past(i_wr) || $past(i_wr, 2); endproperty
   a_fall: assert property (p_fall) else $error("irq dropped unasked");
   property p_clr; i_wr && i_addr == pic_pkg::OFF_CLR_PULSE && i_wdata == 32'hffff_ffff &&
      i_src == 32'h0 && $past(i_src) == 32'h0 && $past(i_src, 2) == 32'h0 &&
      $past(i_src, 3) == 32'h0 |-> ##2 !o_irq [*2]; endproperty
   a_clr: assert property (p_clr) else $error("irq kept after clear");
endmodule // pic_irq_ctrl_chk
bind pic_irq_ctrl pic_irq_ctrl_chk i_pic_irq_ctrl_chk (.i_clk(i_clk), .i_resetn(i_resetn),
   .i_src(i_src), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .o_irq(o_irq));

// [bench/pic_irq_ctrl_bench.sv]
// Self-checking bench of the interrupt block.
`timescale 1ns/1ns
module pic_irq_ctrl_bench;
   localparam logic [31:0] M = pic_pkg::SRC_MASK;
   logic        i_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic [31:0] i_src = 32'h0;
   logic [13:0] i_addr = 14'h0;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic        o_irq;
   logic        rd_d = 1'b0;
   logic [31:0] seed = 32'h67c1cb6b;
   logic [31:0] r;
   logic [31:0] c;
   logic [31:0] exp_q[$];
   logic        irq_q[$];
   logic        irq_go = 1'b0;
   int          n_mismatch = 0;
   int          comparisons = 0;
   pic_irq_ctrl i_pic_irq_ctrl (.i_clk(i_clk), .i_resetn(i_resetn), .i_src(i_src),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_irq(o_irq));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // For a read, d carries the expected answer rather than write data.
   task automatic bus(input logic w, input logic rd, input logic [13:0] a, input logic [31:0] d);
      i_wr <= w;
      i_rd <= rd;
      i_addr <= a;
      i_wdata <= d;
      if (rd) exp_q.push_back(d);
      @(posedge i_clk);
   endtask
   // The level is noted now and compared at the next edge, once the last update has settled.
   task automatic irq_exp(input logic e);
      irq_q.push_back(e);
      irq_go <= 1'b1;
      @(posedge i_clk);
      irq_go <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 14'h0, 32'h0);
   endtask
   task automatic close_out();
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken at the next edge.
   always @(posedge i_clk) begin
      rd_d <= i_rd;
      if (rd_d && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), o_rdata);
      if (irq_go && irq_q.size() > 0) begin
         chk("irq", {31'h0, irq_q.pop_front()}, {31'h0, o_irq});
      end
   end
   initial begin
      forever #20 i_clk = ~i_clk;
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (8) @(posedge i_clk);
      i_resetn <= 1'b1;
      idle(4);
      bus(1'b0, 1'b1, pic_pkg::OFF_EN_READ, 32'h0);
      bus(1'b0, 1'b1, pic_pkg::OFF_STATUS, 32'h0);
      for (int b = 0; b < 32; b++) begin
         bus(1'b1, 1'b0, pic_pkg::OFF_EN_SET, 32'h1 << b);
         bus(1'b0, 1'b1, pic_pkg::OFF_EN_READ, (32'h1 << b) & M);
         bus(1'b1, 1'b0, pic_pkg::OFF_EN_CLEAR, 32'hffff_ffff);
         bus(1'b0, 1'b1, pic_pkg::OFF_EN_READ, 32'h0);
      end
      r = rnd();
      bus(1'b1, 1'b0, pic_pkg::OFF_EN_SET, r);
      bus(1'b0, 1'b1, pic_pkg::OFF_EN_READ, r & M);
      bus(1'b1, 1'b0, pic_pkg::OFF_EN_READ, ~r);
      bus(1'b0, 1'b1, pic_pkg::OFF_EN_READ, r & M);
      bus(1'b1, 1'b0, pic_pkg::OFF_EN_SET, 32'hffff_ffff);
      r = rnd();
      i_src <= r;
      idle(5);
      bus(1'b0, 1'b1, pic_pkg::OFF_STATUS, r & M);
      idle(2);
      irq_exp(|(r & M));
      c = rnd();
      bus(1'b1, 1'b0, pic_pkg::OFF_CLR_PULSE, c);
      idle(3);
      bus(1'b0, 1'b1, pic_pkg::OFF_STATUS, r & M & ~c);
      i_src <= 32'h0;
      idle(4);
      bus(1'b1, 1'b0, pic_pkg::OFF_CLR_PULSE, 32'hffff_ffff);
      idle(2);
      bus(1'b1, 1'b0, pic_pkg::OFF_SET_PULSE, 32'hffff_ffff);
      idle(4);
      bus(1'b0, 1'b1, pic_pkg::OFF_STATUS, M);
      bus(1'b1, 1'b0, pic_pkg::OFF_CLR_PULSE, 32'hffff_ffff);
      idle(3);
      bus(1'b0, 1'b1, pic_pkg::OFF_STATUS, 32'h0);
      bus(1'b0, 1'b1, pic_pkg::OFF_CLR_PULSE, 32'h0);
      bus(1'b0, 1'b1, 14'h0, 32'h0);
      idle(3);
      irq_exp(1'b0);
      close_out();
   end
endmodule // pic_irq_ctrl_bench
